/* File: shared/hbh_pkg.sv */
// Constants, field layouts and state types for the host boot handshake
`default_nettype none
package hbh_pkg;
  // ==========================================================
  // Data path widths
  localparam int DATA_W = 32;
  localparam int RAM_AW = 8;
  localparam int RAM_DEPTH = 256;
  localparam int IRAM_AW = 12;
  localparam int FIFO_DEPTH = 16;
  localparam int IDX_W = 7;
  // ==========================================================
  // Shared RAM layout
  localparam logic [RAM_AW-1:0] BOOT_BASE = 8'h00;
  localparam logic [RAM_AW-1:0] BUF_BASE = 8'h80;
  localparam logic [IDX_W-1:0] IDX_LAST = 7'h7f;
  localparam logic [IDX_W-1:0] IDX_ZERO = 7'h00;
  localparam logic [IDX_W-1:0] IDX_ONE = 7'h01;
  localparam logic [IRAM_AW-1:0] IRAM_ZERO = 12'h000;
  localparam logic [IRAM_AW-1:0] IRAM_ONE = 12'h001;
  // ==========================================================
  // General status register
  localparam int GSR_W = 16;
  localparam int GSR_OWN_BIT = 0;
  localparam int GSR_DONE_BIT = 1;
  localparam logic [GSR_W-1:0] GSR_RST = 16'h0000;
  localparam logic [GSR_W-1:0] GSR_HANDOFF = 16'h0000;
  localparam logic [GSR_W-1:0] GSR_FINISH = 16'h0002;
  // ==========================================================
  // Boot control register
  localparam int BCR_W = 8;
  localparam int BCR_HOLD_BIT = 0;
  localparam logic [BCR_W-1:0] BCR_SET_KEY = 8'ha5;
  localparam logic [BCR_W-1:0] BCR_RELEASE = 8'h00;
  // ==========================================================
  // State machines
  typedef enum logic [2:0] {
    T_HOLD = 3'h0,
    T_BOOT = 3'h1,
    T_GRANT = 3'h2,
    T_WAIT = 3'h3,
    T_COPY = 3'h4,
    T_DRAIN = 3'h5,
    T_RUN = 3'h6
  } hbh_tstate_t;
  typedef enum logic [2:0] {
    H_BOOT = 3'h0,
    H_REL = 3'h1,
    H_POLL = 3'h2,
    H_CHUNK = 3'h3,
    H_HAND = 3'h4,
    H_SETTLE = 3'h5,
    H_FIN = 3'h6,
    H_DONE = 3'h7
  } hbh_hstate_t;
endpackage
`default_nettype wire

/* File: shared/hbh_if.sv */
// Link between the host end and the target end
`default_nettype none
interface hbh_if;
  logic ram_we;
  logic [hbh_pkg::RAM_AW-1:0] ram_addr;
  logic [hbh_pkg::DATA_W-1:0] ram_wdata;
  logic gsr_we;
  logic [hbh_pkg::GSR_W-1:0] gsr_wdata;
  logic bcr_we;
  logic [hbh_pkg::BCR_W-1:0] bcr_wdata;
  logic [hbh_pkg::GSR_W-1:0] gsr;
  logic hold;
  modport host(output ram_we, ram_addr, ram_wdata, gsr_we, gsr_wdata, bcr_we, bcr_wdata, input gsr, hold);
  modport target(input ram_we, ram_addr, ram_wdata, gsr_we, gsr_wdata, bcr_we, bcr_wdata, output gsr, hold);
endinterface
`default_nettype wire

/* File: verilog/hbh_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
`default_nettype none
module hbh_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // ==========================================================
  // Flags
  assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem[rd_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // ==========================================================
  // Storage and pointers
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: verilog/hbh_target.sv */
// Target end: shared RAM, status and boot control registers, chunk copier
// Notes on behaviour
// [R01] Host writes boot program first after reset
// [R02] Host clears boot-hold bit after boot program
// [R03] Target starts boot program when hold clears
// [R04] Host never writes buffer while ownership flag 0
// [R05] Host writes next chunk after seeing flag 1
// [R06] Host clears ownership flag after writing chunk
// [R07] Target waits until ownership flag returns 0
// [R08] Target copies chunk, then sets ownership flag
// [R09] Host finishes: flag 0 with done 1
// [R10] Final step only after all chunk sessions
// [R11] Target runs program on flag 0, done 1
// [R12] Done flag bit 1, ownership bit 0
// [R13] Flag set only when host write possible
// [R14] Flag updates leave other status bits unchanged
// [R15] Status writes visible to next read
`default_nettype none
module hbh_target (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  hbh_if.target link,
  input wire logic i_iram_ready,
  output logic o_iram_valid,
  output logic [hbh_pkg::IRAM_AW-1:0] o_iram_addr,
  output logic [hbh_pkg::DATA_W-1:0] o_iram_data,
  output logic o_boot_run,
  output logic o_prog_run,
  output logic o_copy_busy
);
  import hbh_pkg::*;

  logic [DATA_W-1:0] shared_mem [RAM_DEPTH];
  logic [GSR_W-1:0] gsr_r;
  logic hold_r;
  hbh_tstate_t state_r;
  hbh_tstate_t state_nxt;
  logic [IDX_W-1:0] rd_idx_r;
  logic [IRAM_AW-1:0] iram_ptr_r;
  logic push_valid;
  logic push_ready;
  logic [DATA_W-1:0] push_data;
  logic [RAM_AW-1:0] rd_addr;
  logic fifo_valid;
  logic fifo_ready;
  logic [DATA_W-1:0] fifo_data;
  logic grant;

  // ==========================================================
  // Registers seen by the host
  assign link.gsr = gsr_r;
  assign link.hold = hold_r;

  // ==========================================================
  // Shared RAM, written by the host
  always_ff @(posedge i_clk) begin
    if (i_ce && link.ram_we) begin
      shared_mem[link.ram_addr] <= link.ram_wdata;
    end
  end

  // ==========================================================
  // General status register
  assign grant = (state_r == T_GRANT);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gsr_r <= GSR_RST;
    end else if (i_ce) begin
      if (link.gsr_we) begin
        gsr_r <= link.gsr_wdata; // [R14] [R15]
      end
      if (grant) begin
        gsr_r[GSR_OWN_BIT] <= 1'b1; // [R08] [R13] [R14] [R12]
      end
    end
  end

  // ==========================================================
  // Boot control register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hold_r <= 1'b1;
    end else if (i_ce && link.bcr_we) begin
      if (link.bcr_wdata == BCR_SET_KEY) begin
        hold_r <= 1'b1;
      end else if (!link.bcr_wdata[BCR_HOLD_BIT]) begin
        hold_r <= 1'b0; // [R02]
      end
    end
  end

  // ==========================================================
  // Handshake sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      T_HOLD: begin
        if (!hold_r) begin
          state_nxt = T_BOOT; // [R03]
        end
      end
      T_BOOT: begin
        state_nxt = T_GRANT;
      end
      T_GRANT: begin
        state_nxt = T_WAIT;
      end
      T_WAIT: begin
        if (!gsr_r[GSR_OWN_BIT]) begin
          if (gsr_r[GSR_DONE_BIT]) begin
            state_nxt = T_RUN; // [R11]
          end else begin
            state_nxt = T_COPY; // [R07]
          end
        end
      end
      T_COPY: begin
        if (push_ready && rd_idx_r == IDX_LAST) begin
          state_nxt = T_DRAIN;
        end
      end
      T_DRAIN: begin
        if (!fifo_valid && !o_iram_valid) begin
          state_nxt = T_GRANT; // [R08]
        end
      end
      T_RUN: begin
        state_nxt = T_RUN;
      end
      default: begin
        state_nxt = T_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= T_HOLD;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Buffer reader
  assign push_valid = (state_r == T_COPY);
  assign rd_addr = BUF_BASE + {1'b0, rd_idx_r};
  assign push_data = shared_mem[rd_addr];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_idx_r <= IDX_ZERO;
    end else if (i_ce) begin
      if (push_valid && push_ready) begin
        rd_idx_r <= rd_idx_r + IDX_ONE; // [R08]
      end else if (state_r == T_WAIT) begin
        rd_idx_r <= IDX_ZERO;
      end
    end
  end

  hbh_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) hbh_fifo_i (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready),
    .o_out_data(fifo_data)
  );

  // ==========================================================
  // Internal RAM write port
  assign fifo_ready = !o_iram_valid || i_iram_ready;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_iram_valid <= 1'b0;
      o_iram_addr <= IRAM_ZERO;
      o_iram_data <= '0;
      iram_ptr_r <= IRAM_ZERO;
    end else if (i_ce) begin
      if (fifo_valid && fifo_ready) begin
        o_iram_valid <= 1'b1;
        o_iram_addr <= iram_ptr_r;
        o_iram_data <= fifo_data;
        iram_ptr_r <= iram_ptr_r + IRAM_ONE;
      end else if (i_iram_ready) begin
        o_iram_valid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Run indications
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_boot_run <= 1'b0;
      o_prog_run <= 1'b0;
      o_copy_busy <= 1'b0;
    end else if (i_ce) begin
      if (state_nxt == T_BOOT) begin
        o_boot_run <= 1'b1; // [R03]
      end
      if (state_nxt == T_RUN) begin
        o_prog_run <= 1'b1; // [R11]
      end
      o_copy_busy <= (state_nxt == T_COPY) || (state_nxt == T_DRAIN);
    end
  end
endmodule
`default_nettype wire

/* File: verilog/hbh_host.sv */
// Host end: loads the boot program and streams chunks through the buffer
`default_nettype none
module hbh_host (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  hbh_if.host link,
  input wire logic i_word_valid,
  input wire logic [hbh_pkg::DATA_W-1:0] i_word_data,
  input wire logic i_word_last,
  input wire logic i_no_more,
  output logic o_word_ready,
  output logic o_released,
  output logic o_done
);
  import hbh_pkg::*;

  hbh_hstate_t state_r;
  hbh_hstate_t state_nxt;
  logic [IDX_W-1:0] idx_r;
  logic take;
  logic seg_end;
  logic ram_we_r;
  logic [RAM_AW-1:0] ram_addr_r;
  logic [DATA_W-1:0] ram_wdata_r;
  logic gsr_we_r;
  logic [GSR_W-1:0] gsr_wdata_r;
  logic bcr_we_r;
  logic [BCR_W-1:0] bcr_wdata_r;

  function automatic logic takes_words(input hbh_hstate_t s);
    takes_words = (s == H_BOOT) || (s == H_CHUNK);
  endfunction

  // ==========================================================
  // Link drive
  assign link.ram_we = ram_we_r;
  assign link.ram_addr = ram_addr_r;
  assign link.ram_wdata = ram_wdata_r;
  assign link.gsr_we = gsr_we_r;
  assign link.gsr_wdata = gsr_wdata_r;
  assign link.bcr_we = bcr_we_r;
  assign link.bcr_wdata = bcr_wdata_r;

  assign take = i_word_valid && o_word_ready && takes_words(state_r);
  assign seg_end = take && (i_word_last || idx_r == IDX_LAST);

  // ==========================================================
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      H_BOOT: if (seg_end) begin
        state_nxt = H_REL; // [R01]
      end
      H_REL: state_nxt = H_POLL;
      H_POLL: if (link.gsr[GSR_OWN_BIT]) begin
        state_nxt = i_no_more ? H_FIN : H_CHUNK; // [R04] [R10]
      end
      H_CHUNK: if (seg_end) begin
        state_nxt = H_HAND;
      end
      H_HAND: state_nxt = H_SETTLE;
      H_SETTLE: state_nxt = H_POLL;
      H_FIN: state_nxt = H_DONE;
      H_DONE: state_nxt = H_DONE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= H_BOOT;
      idx_r <= IDX_ZERO;
    end else if (i_ce) begin
      state_r <= state_nxt;
      if (take) begin
        idx_r <= seg_end ? IDX_ZERO : idx_r + IDX_ONE;
      end
    end
  end

  // ==========================================================
  // Shared RAM writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ram_we_r <= 1'b0;
      ram_addr_r <= BOOT_BASE;
      ram_wdata_r <= '0;
    end else if (i_ce) begin
      ram_we_r <= take; // [R05]
      if (take) begin
        ram_addr_r <= ((state_r == H_BOOT) ? BOOT_BASE : BUF_BASE) + {1'b0, idx_r};
        ram_wdata_r <= i_word_data;
      end
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gsr_we_r <= 1'b0;
      gsr_wdata_r <= GSR_RST;
      bcr_we_r <= 1'b0;
      bcr_wdata_r <= BCR_RELEASE;
    end else if (i_ce) begin
      bcr_we_r <= (state_r == H_REL); // [R02]
      bcr_wdata_r <= BCR_RELEASE;
      gsr_we_r <= (state_r == H_HAND) || (state_r == H_FIN);
      gsr_wdata_r <= (state_r == H_FIN) ? GSR_FINISH : GSR_HANDOFF; // [R06] [R09] [R14] [R12]
    end
  end

  // ==========================================================
  // User side status
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_word_ready <= 1'b0;
      o_released <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_word_ready <= takes_words(state_nxt) && !(takes_words(state_r) && seg_end);
      if (state_r == H_REL) begin
        o_released <= 1'b1;
      end
      o_done <= (state_nxt == H_DONE);
    end
  end
endmodule
`default_nettype wire

/* File: verification/hbh_properties.sv */
// Concurrent checks on the link between the host end and the target end
`default_nettype none
module hbh_properties (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic ram_we,
  input wire logic [hbh_pkg::RAM_AW-1:0] ram_addr,
  input wire logic gsr_we,
  input wire logic [hbh_pkg::GSR_W-1:0] gsr_wdata,
  input wire logic bcr_we,
  input wire logic [hbh_pkg::BCR_W-1:0] bcr_wdata,
  input wire logic [hbh_pkg::GSR_W-1:0] gsr,
  input wire logic hold
);
  timeunit 1ns;
  timeprecision 1ps;
  import hbh_pkg::*;
  // ==========================================================
  // Clocking
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // ==========================================================
  // Assertions
  a_boot_area_held: assert property (ram_we && !ram_addr[RAM_AW-1] |-> hold)
    else $error("boot area written after release");
  a_buf_when_owned: assert property (ram_we && ram_addr[RAM_AW-1] |-> !hold && gsr[GSR_OWN_BIT])
    else $error("buffer written without ownership");
  a_hold_release: assert property (bcr_we && !bcr_wdata[BCR_HOLD_BIT] && bcr_wdata != BCR_SET_KEY
    |-> ##[1:2] !hold)
    else $error("hold not released after control write");
  a_hold_cause: assert property ($fell(hold) |-> $past(bcr_we) || $past(bcr_we, 2))
    else $error("hold dropped without control write");
  a_status_write_own: assert property (gsr_we |-> gsr[GSR_OWN_BIT] && !gsr[GSR_DONE_BIT])
    else $error("status written while target owns buffer");
  a_status_write_val: assert property (gsr_we |-> gsr_wdata == GSR_HANDOFF || gsr_wdata == GSR_FINISH)
    else $error("status written with unexpected word");
  a_handoff_seen: assert property (gsr_we && gsr_wdata == GSR_HANDOFF |-> ##[1:3] !gsr[GSR_OWN_BIT])
    else $error("handoff not visible");
  a_finish_seen: assert property (gsr_we && gsr_wdata == GSR_FINISH |-> ##[1:3] gsr == GSR_FINISH)
    else $error("finish not visible");
  a_set_after_boot: assert property ($rose(gsr[GSR_OWN_BIT]) |-> !hold && !gsr[GSR_DONE_BIT])
    else $error("ownership set at wrong time");
  a_clear_by_host: assert property ($fell(gsr[GSR_OWN_BIT])
    |-> $past(gsr_we) || $past(gsr_we, 2) || $past(gsr_we, 3))
    else $error("ownership cleared without host write");
  a_upper_bits_zero: assert property (gsr[GSR_W-1:GSR_DONE_BIT+1] == '0)
    else $error("unused status bits changed");
  // ==========================================================
  // Coverage
  c_release: cover property (bcr_we ##[1:2] !hold);
  c_handoff: cover property (gsr_we && gsr_wdata == GSR_HANDOFF);
  c_finish: cover property (gsr == GSR_FINISH);
endmodule
`default_nettype wire

/* File: verification/tb_host_boot_handshake.sv */
// Self-checking bench joining the host end and the target end
`default_nettype none
module tb_host_boot_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  import hbh_pkg::*;
  localparam int LIM = 4000;
  logic i_clk, i_arst_n, i_ce, word_valid, word_last, no_more, iram_ready;
  logic word_ready, released, done, iram_valid, boot_run, prog_run, copy_busy;
  logic [DATA_W-1:0] word_data, iram_data;
  logic [IRAM_AW-1:0] iram_addr;
  logic [DATA_W-1:0] sram [0:RAM_DEPTH-1];
  logic [DATA_W-1:0] iram [0:511];
  logic [DATA_W-1:0] bufm [0:127];
  int miscompares, samples_checked, nwr;
  // ==========================================================
  // Design
  hbh_if hbh_if_i ();
  hbh_host hbh_host_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .link(hbh_if_i),
    .i_word_valid(word_valid), .i_word_data(word_data), .i_word_last(word_last), .i_no_more(no_more),
    .o_word_ready(word_ready), .o_released(released), .o_done(done));
  hbh_target hbh_target_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .link(hbh_if_i),
    .i_iram_ready(iram_ready), .o_iram_valid(iram_valid), .o_iram_addr(iram_addr), .o_iram_data(iram_data),
    .o_boot_run(boot_run), .o_prog_run(prog_run), .o_copy_busy(copy_busy));
  hbh_properties hbh_properties_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .ram_we(hbh_if_i.ram_we),
    .ram_addr(hbh_if_i.ram_addr), .gsr_we(hbh_if_i.gsr_we), .gsr_wdata(hbh_if_i.gsr_wdata),
    .bcr_we(hbh_if_i.bcr_we), .bcr_wdata(hbh_if_i.bcr_wdata), .gsr(hbh_if_i.gsr), .hold(hbh_if_i.hold));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [DATA_W-1:0] word_of(input int s, input int k);
    return {8'h5a, 8'(s), 16'(k)};
  endfunction
  task check(input string what, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task to_chk(input int g);
    if (g >= LIM) begin
      miscompares++;
      $display("CHECK FAILED wait expected done seen timeout");
      close_out;
    end
  endtask
  task send_seg(input int s, input int n);
    int g;
    for (int k = 0; k < n; k++) begin
      @(negedge i_clk);
      word_valid = 1'b1;
      word_data = word_of(s, k);
      word_last = (k == n - 1);
      for (g = 0; g < LIM && word_ready !== 1'b1; g++) @(negedge i_clk);
      to_chk(g);
      @(posedge i_clk);
    end
    @(negedge i_clk);
    word_valid = 1'b0;
    word_last = 1'b0;
  endtask
  // ==========================================================
  // Shared RAM and internal RAM observers
  always @(posedge i_clk) begin
    if (hbh_if_i.ram_we === 1'b1) sram[hbh_if_i.ram_addr] = hbh_if_i.ram_wdata;
    if (iram_valid === 1'b1 && iram_ready === 1'b1) begin
      iram[iram_addr[8:0]] = iram_data;
      nwr++;
      check("own_flag_in_copy", hbh_if_i.gsr[GSR_OWN_BIT], 1'b0);
    end
  end
  // ==========================================================
  // Scenarios
  task t_reset;
    i_arst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    check("hold_in_reset", hbh_if_i.hold, 1'b1);
    check("gsr_in_reset", hbh_if_i.gsr, GSR_RST);
    check("boot_run_in_reset", boot_run, 1'b0);
    repeat (3) @(negedge i_clk);
    i_arst_n = 1'b1;
    $display("test reset finished");
  endtask
  task t_boot;
    int g;
    send_seg(0, 4);
    check("boot_run_early", boot_run, 1'b0);
    check("own_early", hbh_if_i.gsr[GSR_OWN_BIT], 1'b0);
    for (g = 0; g < LIM && boot_run !== 1'b1; g++) @(negedge i_clk);
    to_chk(g);
    check("hold_after_release", hbh_if_i.hold, 1'b0);
    check("released", released, 1'b1);
    for (int k = 0; k < 4; k++) check("boot_word", sram[BOOT_BASE + k], word_of(0, k));
    for (g = 0; g < LIM && hbh_if_i.gsr[GSR_OWN_BIT] !== 1'b1; g++) @(negedge i_clk);
    to_chk(g);
    check("prog_run_after_boot", prog_run, 1'b0);
    $display("test boot finished");
  endtask
  task t_chunk(input int s, input int n, input logic stall, input logic fin);
    int g;
    if (stall) iram_ready = 1'b0;
    send_seg(s, n);
    for (int k = 0; k < n; k++) bufm[k] = word_of(s, k);
    no_more = fin;
    for (g = 0; g < LIM && hbh_if_i.gsr[GSR_OWN_BIT] !== 1'b0; g++) @(negedge i_clk);
    to_chk(g);
    for (int k = 0; k < n; k++) check("buf_word", sram[BUF_BASE + k], word_of(s, k));
    if (stall) begin
      repeat (40) @(negedge i_clk);
      check("stalled_valid", iram_valid, 1'b1);
      check("stalled_busy", copy_busy, 1'b1);
      check("stalled_own", hbh_if_i.gsr[GSR_OWN_BIT], 1'b0);
      iram_ready = 1'b1;
    end
    for (g = 0; g < LIM && hbh_if_i.gsr[GSR_OWN_BIT] !== 1'b1; g++) @(negedge i_clk);
    to_chk(g);
    check("copy_count", nwr, s * 128);
    for (int k = 0; k < 128; k++) check("iram_word", iram[(s - 1) * 128 + k], bufm[k]);
    check("prog_run_early", prog_run, 1'b0);
    $display("test chunk %0d finished", s);
  endtask
  task t_finish;
    int g;
    for (g = 0; g < LIM && prog_run !== 1'b1; g++) @(negedge i_clk);
    to_chk(g);
    check("final_status", hbh_if_i.gsr, GSR_FINISH);
    check("host_done", done, 1'b1);
    check("ready_after_done", word_ready, 1'b0);
    check("no_extra_copy", nwr, 384);
    $display("test finish finished");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    i_arst_n = 1'b0;
    i_ce = 1'b1;
    word_valid = 1'b0;
    word_data = '0;
    word_last = 1'b0;
    no_more = 1'b0;
    iram_ready = 1'b1;
    miscompares = 0;
    samples_checked = 0;
    nwr = 0;
    t_reset;
    t_boot;
    t_chunk(1, 128, 1'b0, 1'b0);
    t_chunk(2, 1, 1'b1, 1'b0);
    t_chunk(3, 5, 1'b0, 1'b1);
    t_finish;
    close_out;
  end
endmodule
`default_nettype wire
